// [hw/scsc_clock_switch.sv]
// system clock switch control: source and frequency selection, sequenced glitch-free changeover
// assumes oscillator ready/stable flags and the running clock level arrive as pins from other domains
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "scsc_defines.svh"

module scsc_clock_switch #(
  parameter int MUL_LOCK_CYC = (`SCSC_MUL_LOCK_NS + `SCSC_CLK_PERIOD_NS - 1) / `SCSC_CLK_PERIOD_NS,
  parameter int WARM_CYC = (`SCSC_WARM_NS + `SCSC_CLK_PERIOD_NS - 1) / `SCSC_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [`SCSC_ADDR_W-1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [7:0] rdData,
  input wire logic [1:0] defaultSourceConfig,
  input wire logic fastOscReadyIn,
  input wire logic slowOscReadyIn,
  input wire logic fastOscStableIn,
  input wire logic curClkLevel,
  input wire logic sleepWake,
  output logic sysSrcInternal,
  output logic [3:0] activeFreqSelect,
  output logic multiplierOn,
  output logic fastOscEnable,
  output logic slowOscEnable,
  output logic clockHold,
  output logic switchBusy
);

  localparam logic [`SCSC_TMR_W-1:0] FAST_LOAD = `SCSC_TMR_W'(`SCSC_FAST_START_CYC);
  localparam logic [`SCSC_TMR_W-1:0] MUL_LOAD = `SCSC_TMR_W'(MUL_LOCK_CYC);
  localparam logic [`SCSC_TMR_W-1:0] WARM_LOAD = `SCSC_TMR_W'(WARM_CYC);

  scsc_pkg::scsc_state_type q;
  scsc_pkg::scsc_state_type d;

  scsc_timer_if #(.W(`SCSC_TMR_W)) tmr ();

  scsc_delay_timer #(.W(`SCSC_TMR_W)) u_timer (
    .clk(clk),
    .reset(reset),
    .tmr(tmr.timer)
  );

  // helper terms, also watched by the assertions
  logic [1:0] scsField;
  logic [1:0] cfgSrc;
  logic cfgInt;
  logic reqInt;
  logic reqMul;
  logic useInt;
  logic pending;
  logic fallEdge;
  logic tgtOff;
  logic sameSrc;
  logic [7:0] statusWord;

  // requested selection and its relation to the committed one
  always_comb
  begin
    scsField = q.ctl[`SCSC_CTL_SCS_HI:`SCSC_CTL_SCS_LO];
    cfgSrc = q.sync2[`SCSC_PIN_CFG_HI:`SCSC_PIN_CFG_LO];
    cfgInt = (cfgSrc == `SCSC_CFG_INTERNAL);
    // reserved select keeps whatever source is running
    if (scsField[1])
      reqInt = 1'b1;
    else if (scsField == `SCSC_SCS_RESERVED)
      reqInt = q.srcInt;
    else
      reqInt = 1'b0;
    // multiplier only behind the configured internal source
    reqMul = q.ctl[`SCSC_CTL_MUL_BIT] & (scsField == `SCSC_SCS_DEFAULT) & cfgInt;
    useInt = reqInt | cfgInt;
    pending = (reqInt != q.srcInt) | (reqMul != q.mulOn) |
              (useInt & (q.ctl[`SCSC_CTL_FREQ_HI:`SCSC_CTL_FREQ_LO] != q.freq));
    sameSrc = (scsc_pkg::oscOfFreq(q.ctl[`SCSC_CTL_FREQ_HI:`SCSC_CTL_FREQ_LO]) == scsc_pkg::oscOfFreq(q.freq));
    // medium and fast codes both hang off the fast oscillator
    if (scsc_pkg::oscOfFreq(q.ctl[`SCSC_CTL_FREQ_HI:`SCSC_CTL_FREQ_LO]) == scsc_pkg::SCSC_OSC_SLOW)
      tgtOff = ~q.sync2[`SCSC_PIN_SLOW_RDY];
    else
      tgtOff = ~q.sync2[`SCSC_PIN_FAST_RDY];
    // edge detector reads only the second synchroniser stage and its delayed copy
    fallEdge = q.clkPrev & ~q.sync2[`SCSC_PIN_CUR_CLK];
    statusWord = 8'h00;
    statusWord[`SCSC_STAT_MUL_RDY] = q.mulReady;
    statusWord[`SCSC_STAT_FAST_RDY] = q.sync2[`SCSC_PIN_FAST_RDY];
    statusWord[`SCSC_STAT_SLOW_RDY] = q.sync2[`SCSC_PIN_SLOW_RDY];
    statusWord[`SCSC_STAT_FAST_STB] = q.sync2[`SCSC_PIN_FAST_STB];
  end

  // next state: synchronisers, register port, switch sequencer
  always_comb
  begin
    d = q;
    d.sync1 = {defaultSourceConfig, curClkLevel, fastOscStableIn, slowOscReadyIn, fastOscReadyIn};
    d.sync2 = q.sync1;
    d.clkPrev = q.sync2[`SCSC_PIN_CUR_CLK];
    d.tmrStart = 1'b0;
    d.rdData = 8'h00;
    // writes land in control; bit 2 and status are not writable
    if (wrEn && addr == `SCSC_ADDR_CTL)
      d.ctl = wrData & `SCSC_CTL_WMASK;
    // read data stand for exactly the cycle after the strobe
    if (rdEn)
    begin
      if (addr == `SCSC_ADDR_CTL)
        d.rdData = q.ctl;
      else if (addr == `SCSC_ADDR_STAT)
        d.rdData = statusWord;
      else
        d.rdData = 8'h00;
    end
    case (q.fsm)
      scsc_pkg::SCSC_ST_RUN:
      begin
        // a wake request outranks a pending change; the change is picked up afterwards
        if (sleepWake && useInt && !q.mulOn)
        begin
          d.hold = 1'b1;
          d.tmrStart = 1'b1;
          d.tmrLoad = WARM_LOAD;
          d.fsm = scsc_pkg::SCSC_ST_WARM;
        end
        else if (pending)
        begin
          d.tgtInt = reqInt;
          d.tgtFreq = q.ctl[`SCSC_CTL_FREQ_HI:`SCSC_CTL_FREQ_LO];
          d.tgtMul = reqMul;
          if ((reqInt | cfgInt) && !sameSrc && tgtOff)
          begin
            d.tmrStart = 1'b1;
            d.tmrLoad = FAST_LOAD;
            d.fsm = scsc_pkg::SCSC_ST_STARTUP;
          end
          else
            d.fsm = scsc_pkg::SCSC_ST_EDGE;
        end
      end
      scsc_pkg::SCSC_ST_STARTUP:
      begin
        if (tmr.done)
          d.fsm = scsc_pkg::SCSC_ST_EDGE;
      end
      scsc_pkg::SCSC_ST_EDGE:
      begin
        // commit only while the running clock is low, so no runt pulse reaches the core
        if (fallEdge)
        begin
          d.srcInt = q.tgtInt;
          d.freq = q.tgtFreq;
          d.mulOn = q.tgtMul;
          if (q.tgtMul && !q.mulOn)
          begin
            d.mulReady = 1'b0;
            d.tmrStart = 1'b1;
            d.tmrLoad = MUL_LOAD;
            d.fsm = scsc_pkg::SCSC_ST_MUL_LOCK;
          end
          else
          begin
            d.mulReady = q.tgtMul & q.mulReady;
            d.fsm = scsc_pkg::SCSC_ST_RUN;
          end
        end
      end
      scsc_pkg::SCSC_ST_MUL_LOCK:
      begin
        if (tmr.done)
        begin
          d.mulReady = 1'b1;
          d.fsm = scsc_pkg::SCSC_ST_RUN;
        end
      end
      scsc_pkg::SCSC_ST_WARM:
      begin
        if (tmr.done)
        begin
          d.hold = 1'b0;
          d.fsm = scsc_pkg::SCSC_ST_RUN;
        end
      end
      default:
        d.fsm = scsc_pkg::SCSC_ST_RUN;
    endcase
    d.busy = (d.fsm != scsc_pkg::SCSC_ST_RUN);
    // keep an oscillator powered while it runs the core or is being brought up
    d.fastEn = ((d.srcInt | cfgInt) && scsc_pkg::oscOfFreq(d.freq) != scsc_pkg::SCSC_OSC_SLOW) ||
               d.fsm == scsc_pkg::SCSC_ST_STARTUP || d.mulOn ||
               (d.fsm == scsc_pkg::SCSC_ST_EDGE && scsc_pkg::oscOfFreq(d.tgtFreq) != scsc_pkg::SCSC_OSC_SLOW);
    d.slowEn = ((d.srcInt | cfgInt) && scsc_pkg::oscOfFreq(d.freq) == scsc_pkg::SCSC_OSC_SLOW) ||
               (d.fsm != scsc_pkg::SCSC_ST_RUN && scsc_pkg::oscOfFreq(d.tgtFreq) == scsc_pkg::SCSC_OSC_SLOW);
  end

  // every reset returns to the configured source at 500 kHz
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      q <= '0;
      q.ctl <= `SCSC_CTL_RESET;
      q.freq <= `SCSC_FREQ_RESET;
      q.tgtFreq <= `SCSC_FREQ_RESET;
      q.fsm <= scsc_pkg::SCSC_ST_RUN;
    end
    else
      q <= d;
  end

  assign tmr.start = q.tmrStart;
  assign tmr.load = q.tmrLoad;

  assign rdData = q.rdData;
  assign sysSrcInternal = q.srcInt;
  assign activeFreqSelect = q.freq;
  assign multiplierOn = q.mulOn;
  assign fastOscEnable = q.fastEn;
  assign slowOscEnable = q.slowEn;
  assign clockHold = q.hold;
  assign switchBusy = q.busy;

  // checks of the sequencing and register behaviour
  localparam int AST_FAST_MAX = 260;

  AST_RESET_VALUES: assert property (@(posedge clk) $fell(reset) |->
    (q.ctl[1:0] == 2'h0 && !q.srcInt && q.ctl[6:3] == 4'h7))
    else $error("control not at reset value after reset");

  AST_STARTUP_HOLDS_SEL: assert property (@(posedge clk) disable iff (reset)
    (q.fsm == scsc_pkg::SCSC_ST_STARTUP) |=> ($stable(q.freq) && $stable(q.srcInt)))
    else $error("selection changed during oscillator start-up");

  AST_EDGE_WAIT: assert property (@(posedge clk) disable iff (reset)
    (q.fsm == scsc_pkg::SCSC_ST_EDGE && !fallEdge) |=> (q.fsm == scsc_pkg::SCSC_ST_EDGE && $stable(q.freq)))
    else $error("switch completed without a falling edge");

  AST_SAME_SOURCE: assert property (@(posedge clk) disable iff (reset)
    (q.fsm == scsc_pkg::SCSC_ST_RUN && pending && sameSrc && !sleepWake) |=> (q.fsm == scsc_pkg::SCSC_ST_EDGE))
    else $error("same-source change took a start-up delay");

  AST_FAST_START_BOUND: assert property (@(posedge clk) disable iff (reset)
    $rose(q.fsm == scsc_pkg::SCSC_ST_STARTUP) |-> ##[190:AST_FAST_MAX] (q.fsm == scsc_pkg::SCSC_ST_EDGE))
    else $error("oscillator start-up delay out of range");

  AST_MUL_ONLY_DEFAULT: assert property (@(posedge clk) disable iff (reset)
    q.mulOn |-> !q.srcInt)
    else $error("multiplier active with internal clock select");

  AST_STATUS_FAST_RDY: assert property (@(posedge clk) disable iff (reset)
    (rdEn && addr == `SCSC_ADDR_STAT) |=> (rdData[4] == $past(q.sync2[`SCSC_PIN_FAST_RDY]) && rdData[6] == $past(q.mulReady)))
    else $error("status read does not match oscillator state");

  AST_CTL_WRITE: assert property (@(posedge clk) disable iff (reset)
    (wrEn && addr == `SCSC_ADDR_CTL) ##1 (rdEn && addr == `SCSC_ADDR_CTL) |=> (rdData[7] == $past(wrData[7], 2) && rdData[2] == 1'b0))
    else $error("control write not reflected on read");

  AST_WARM_HOLD: assert property (@(posedge clk) disable iff (reset)
    (q.fsm == scsc_pkg::SCSC_ST_RUN && sleepWake && useInt && !q.mulOn) |=> (clockHold && q.fsm == scsc_pkg::SCSC_ST_WARM))
    else $error("wake did not apply warm-up hold");

  COV_SLOW_TO_FAST: cover property (@(posedge clk) disable iff (reset)
    $rose(q.fsm == scsc_pkg::SCSC_ST_STARTUP));
  COV_MUL_READY: cover property (@(posedge clk) disable iff (reset) $rose(q.mulReady));
  COV_WAKE: cover property (@(posedge clk) disable iff (reset) $fell(clockHold));
  COV_INTERNAL: cover property (@(posedge clk) disable iff (reset) $rose(q.srcInt));

endmodule : scsc_clock_switch

`default_nettype wire

// [hw/scsc_defines.svh]
// constants of the system clock switch control: register map, field positions, reset values, timing
// assumes a 100 MHz core clock; included by the package and by every design file
`ifndef SCSC_DEFINES_SVH
`define SCSC_DEFINES_SVH

// register map on the plain software port
`define SCSC_ADDR_W 4
`define SCSC_ADDR_CTL 4'h0
`define SCSC_ADDR_STAT 4'h1

// oscillator_control fields
`define SCSC_CTL_RESET 8'h38
`define SCSC_CTL_WMASK 8'hfb
`define SCSC_CTL_MUL_BIT 7
`define SCSC_CTL_FREQ_HI 6
`define SCSC_CTL_FREQ_LO 3
`define SCSC_CTL_SCS_HI 1
`define SCSC_CTL_SCS_LO 0

// oscillator_status fields
`define SCSC_STAT_MUL_RDY 6
`define SCSC_STAT_FAST_RDY 4
`define SCSC_STAT_SLOW_RDY 1
`define SCSC_STAT_FAST_STB 0

// field codes
`define SCSC_FREQ_RESET 4'h7
`define SCSC_FREQ_FAST_MIN 4'h8
`define SCSC_FREQ_MED_MIN 4'h2
`define SCSC_SCS_DEFAULT 2'h0
`define SCSC_SCS_RESERVED 2'h1
`define SCSC_CFG_INTERNAL 2'h0

// pin vector positions after synchronisation
`define SCSC_PIN_W 6
`define SCSC_PIN_FAST_RDY 0
`define SCSC_PIN_SLOW_RDY 1
`define SCSC_PIN_FAST_STB 2
`define SCSC_PIN_CUR_CLK 3
`define SCSC_PIN_CFG_LO 4
`define SCSC_PIN_CFG_HI 5

// timing
`define SCSC_CLK_PERIOD_NS 10
`define SCSC_FAST_START_NS 2000
`define SCSC_MUL_LOCK_NS 2000000
`define SCSC_WARM_NS 5000
`define SCSC_TMR_W 18
`define SCSC_FAST_START_CYC ((`SCSC_FAST_START_NS + `SCSC_CLK_PERIOD_NS - 1) / `SCSC_CLK_PERIOD_NS)

`endif

// [hw/scsc_delay_timer.sv]
// down counter that times oscillator start-up, multiplier lock and wake warm-up
// assumes start is a one-cycle pulse from the sequencer on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "scsc_defines.svh"

module scsc_delay_timer #(
  parameter int W = `SCSC_TMR_W
) (
  input wire logic clk,
  input wire logic reset,
  scsc_timer_if.timer tmr
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } scsc_tmr_state_type;

  scsc_tmr_state_type q;
  scsc_tmr_state_type d;

  // a new start restarts the count, so a later request always wins
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    if (tmr.start)
      d.cnt = tmr.load;
    else if (q.cnt != '0)
    begin
      d.cnt = q.cnt - W'(1);
      d.done = (q.cnt == W'(1));
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      q <= '0;
    else
      q <= d;
  end

  assign tmr.busy = (q.cnt != '0);
  assign tmr.done = q.done;

endmodule : scsc_delay_timer

`default_nettype wire

// [hw/scsc_pkg.sv]
// types used by the clock switch control; its delay timer keeps its own state type
// assumes scsc_defines.svh is reachable by bare name
`include "scsc_defines.svh"

package scsc_pkg;

  // which internal oscillator a frequency code draws from
  typedef enum logic [1:0] {SCSC_OSC_SLOW, SCSC_OSC_MED, SCSC_OSC_FAST} scsc_osc_type;

  typedef enum logic [2:0] {SCSC_ST_RUN, SCSC_ST_STARTUP, SCSC_ST_EDGE, SCSC_ST_MUL_LOCK, SCSC_ST_WARM} scsc_fsm_type;

  typedef struct packed {
    logic [`SCSC_PIN_W-1:0] sync1;
    logic [`SCSC_PIN_W-1:0] sync2;
    logic clkPrev;
    logic [7:0] ctl;
    logic srcInt;
    logic [3:0] freq;
    logic mulOn;
    logic mulReady;
    scsc_fsm_type fsm;
    logic tgtInt;
    logic [3:0] tgtFreq;
    logic tgtMul;
    logic hold;
    logic busy;
    logic fastEn;
    logic slowEn;
    logic tmrStart;
    logic [`SCSC_TMR_W-1:0] tmrLoad;
    logic [7:0] rdData;
  } scsc_state_type;

  // 000x slow, 001x..0111 medium, 1xxx fast
  function automatic scsc_osc_type oscOfFreq(input logic [3:0] code);
    if (code >= `SCSC_FREQ_FAST_MIN)
      return SCSC_OSC_FAST;
    else if (code >= `SCSC_FREQ_MED_MIN)
      return SCSC_OSC_MED;
    else
      return SCSC_OSC_SLOW;
  endfunction : oscOfFreq

endpackage : scsc_pkg

// [hw/scsc_timer_if.sv]
// start/done handshake between the switch sequencer and its delay timer
// assumes both ends share one clock
`timescale 1ns/100ps
`default_nettype none
`include "scsc_defines.svh"

interface scsc_timer_if #(parameter int W = `SCSC_TMR_W);
  logic start;
  logic [W-1:0] load;
  logic busy;
  logic done;

  modport ctrl (output start, output load, input busy, input done);
  modport timer (input start, input load, output busy, output done);
endinterface : scsc_timer_if

`default_nettype wire

// [testbench/system_clock_switch_control_tb.sv]
// self-checking bench for the system clock switch control
// assumes the design files under hw/ are compiled first; drives all ports itself
`timescale 1ns/100ps
`default_nettype none
`include "scsc_defines.svh"

module system_clock_switch_control_tb;
  logic clk, reset, wrEn, rdEn, sleepWake, curClkLevel, clkRun;
  logic fastOscReadyIn, slowOscReadyIn, fastOscStableIn;
  logic [`SCSC_ADDR_W-1:0] addr;
  logic [7:0] wrData, rdData, rd;
  logic [1:0] defaultSourceConfig;
  logic sysSrcInternal, multiplierOn, fastOscEnable, slowOscEnable, clockHold, switchBusy;
  logic [3:0] activeFreqSelect;
  logic [2:0] divCnt;
  int errCount, cmpCount, n;

  // shortened lock and warm-up counts keep the run brief
  scsc_clock_switch #(.MUL_LOCK_CYC(50), .WARM_CYC(20)) scsc_clock_switch_i (
    .clk(clk), .reset(reset), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .defaultSourceConfig(defaultSourceConfig), .fastOscReadyIn(fastOscReadyIn),
    .slowOscReadyIn(slowOscReadyIn), .fastOscStableIn(fastOscStableIn), .curClkLevel(curClkLevel),
    .sleepWake(sleepWake), .sysSrcInternal(sysSrcInternal), .activeFreqSelect(activeFreqSelect),
    .multiplierOn(multiplierOn), .fastOscEnable(fastOscEnable), .slowOscEnable(slowOscEnable),
    .clockHold(clockHold), .switchBusy(switchBusy));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // running system clock level, parked high when stopped so no falling edge can appear
  always @(posedge clk)
  begin
    divCnt <= divCnt + 3'h1;
    curClkLevel <= clkRun ? divCnt[2] : 1'b1;
  end

  task automatic wrapUp;
    $display("comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrapUp

  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      errCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkByte

  task automatic chkBit(input logic got, input logic exp);
    chkByte({7'h00, got}, {7'h00, exp});
  endtask : chkBit

  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask : regWrite

  // read data stand only in the cycle after the strobe
  task automatic regRead(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    d = rdData;
  endtask : regRead

  function automatic logic [3:0] pick(input int sel);
    case (sel)
      0: return {3'h0, sysSrcInternal};
      1: return {3'h0, multiplierOn};
      2: return {3'h0, clockHold};
      3: return {3'h0, switchBusy};
      default: return activeFreqSelect;
    endcase
  endfunction : pick

  // bounded wait; running out counts a mismatch and ends the run
  task automatic waitSig(input int sel, input logic [3:0] val, input int maxCyc, output int cnt);
    cnt = 0;
    // step off the edge so the design's outputs have settled
    #1;
    while (pick(sel) !== val)
    begin
      if (cnt >= maxCyc)
      begin
        errCount++;
        $display("wrong value at %0t: got %h expected %h", $time, pick(sel), val);
        wrapUp();
      end
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask : waitSig

  task automatic testReset;
    regRead(4'h0, rd);
    chkByte(rd, 8'h38);
    chkByte({4'h0, activeFreqSelect}, 8'h07);
    chkBit(sysSrcInternal, 1'b0);
    $display("reset values done");
  endtask : testReset

  task automatic testStatus;
    fastOscReadyIn <= 1'b1;
    slowOscReadyIn <= 1'b0;
    fastOscStableIn <= 1'b1;
    repeat (4) @(posedge clk);
    regRead(4'h1, rd);
    chkByte(rd, 8'h11);
    fastOscReadyIn <= 1'b0;
    slowOscReadyIn <= 1'b1;
    fastOscStableIn <= 1'b0;
    repeat (4) @(posedge clk);
    regRead(4'h1, rd);
    chkByte(rd, 8'h02);
    fastOscReadyIn <= 1'b1;
    fastOscStableIn <= 1'b1;
    repeat (4) @(posedge clk);
    $display("status flags done");
  endtask : testStatus

  task automatic testMask;
    regWrite(4'h0, 8'h3c);
    regWrite(4'h1, 8'hff);
    regWrite(4'h5, 8'haa);
    regRead(4'h0, rd);
    chkByte(rd, 8'h38);
    regRead(4'h1, rd);
    chkByte(rd, 8'h13);
    regRead(4'h5, rd);
    chkByte(rd, 8'h00);
    // write then read with no gap between the strobes
    @(posedge clk);
    addr <= 4'h0;
    wrData <= 8'h3c;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    chkByte(rdData, 8'h38);
    $display("unimplemented bits done");
  endtask : testMask

  // with the running clock parked high the switch must not complete
  task automatic testSameSource;
    clkRun <= 1'b0;
    regWrite(4'h0, 8'h72);
    repeat (30) @(posedge clk);
    #1;
    chkByte({4'h0, activeFreqSelect}, 8'h07);
    chkBit(switchBusy, 1'b1);
    clkRun <= 1'b1;
    waitSig(4, 4'he, 20, n);
    chkBit(sysSrcInternal, 1'b1);
    $display("same source switch done");
  endtask : testSameSource

  task automatic testStartup;
    regWrite(4'h0, 8'h02);
    waitSig(4, 4'h0, 40, n);
    chkBit(slowOscEnable, 1'b1);
    chkBit(fastOscEnable, 1'b0);
    fastOscReadyIn <= 1'b0;
    repeat (4) @(posedge clk);
    regWrite(4'h0, 8'h52);
    waitSig(4, 4'ha, 400, n);
    chkBit(n >= 200, 1'b1);
    chkBit(fastOscEnable, 1'b1);
    fastOscReadyIn <= 1'b1;
    $display("start-up delay done");
  endtask : testStartup

  task automatic testMultiplier;
    regWrite(4'h0, 8'hf0);
    waitSig(1, 4'h1, 60, n);
    regRead(4'h1, rd);
    chkByte(rd, 8'h13);
    repeat (70) @(posedge clk);
    regRead(4'h1, rd);
    chkByte(rd, 8'h53);
    regRead(4'h0, rd);
    chkByte(rd, 8'hf0);
    $display("multiplier done");
  endtask : testMultiplier

  // external configurations must never engage the multiplier
  task automatic testSelect;
    regWrite(4'h0, 8'hf2);
    waitSig(1, 4'h0, 40, n);
    chkBit(sysSrcInternal, 1'b1);
    for (int c = 1; c < 4; c++)
    begin
      defaultSourceConfig <= c[1:0];
      repeat (4) @(posedge clk);
      regWrite(4'h0, 8'hf0);
      waitSig(0, 4'h0, 40, n);
      repeat (10) @(posedge clk);
      #1;
      chkBit(multiplierOn, 1'b0);
      regWrite(4'h0, 8'hf2);
      waitSig(0, 4'h1, 40, n);
    end
    defaultSourceConfig <= 2'h0;
    $display("source select done");
  endtask : testSelect

  task automatic testWake;
    regWrite(4'h0, 8'h7a);
    waitSig(4, 4'hf, 40, n);
    waitSig(3, 4'h0, 10, n);
    @(posedge clk);
    sleepWake <= 1'b1;
    @(posedge clk);
    sleepWake <= 1'b0;
    #1;
    chkBit(clockHold, 1'b1);
    waitSig(2, 4'h0, 60, n);
    chkBit(n >= 20, 1'b1);
    $display("wake warm-up done");
  endtask : testWake

  // a second reset in mid-sequence must bring back the configured source
  task automatic testMidReset;
    regWrite(4'h0, 8'h72);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    regRead(4'h0, rd);
    chkByte(rd, 8'h38);
    chkBit(sysSrcInternal, 1'b0);
    $display("mid-run reset done");
  endtask : testMidReset

  initial
  begin
    errCount = 0;
    cmpCount = 0;
    reset = 1'b1;
    addr = '0;
    wrData = 8'h00;
    wrEn = 1'b0;
    rdEn = 1'b0;
    sleepWake = 1'b0;
    clkRun = 1'b1;
    divCnt = 3'h0;
    curClkLevel = 1'b1;
    defaultSourceConfig = 2'h0;
    fastOscReadyIn = 1'b1;
    slowOscReadyIn = 1'b1;
    fastOscStableIn = 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    testReset();
    testStatus();
    testMask();
    testSameSource();
    testStartup();
    testMultiplier();
    testSelect();
    testWake();
    testMidReset();
    wrapUp();
  end
endmodule : system_clock_switch_control_tb

`default_nettype wire
